// >>> rxr_apb_regs.sv
`include "rxr_defines.svh"
`default_nettype none
module rxr_apb_regs #(
  parameter logic [2:0] LOG2_MAX = 3'h7
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Block side
  output logic run,
  output logic [23:0] ring_base,
  output logic [2:0] ring_log2,
  input wire logic [6:0] idx,
  input wire logic [3:0] state
);
  logic mapped;
  logic wr;
  logic [31:0] rd_next;

  assign mapped = (paddr == `RXR_CTRL_OFS) || (paddr == `RXR_BASE_OFS) ||
                  (paddr == `RXR_LEN_OFS) || (paddr == `RXR_STAT_OFS);
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign wr = psel && penable && pwrite;

  always_comb begin
    case (paddr)
      `RXR_CTRL_OFS: rd_next = {31'h0, run};
      `RXR_BASE_OFS: rd_next = {8'h00, ring_base};
      `RXR_LEN_OFS: rd_next = {29'h0, ring_log2};
      `RXR_STAT_OFS: rd_next = {12'h000, state, 9'h000, idx};
      default: rd_next = 32'h00000000;
    endcase
  end

  // Read data is captured in the setup phase so it comes from a flop
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      prdata <= 32'h00000000;
    end else if (psel && !penable) begin
      prdata <= pwrite ? 32'h00000000 : rd_next;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      run <= 1'b0;
      ring_base <= `RXR_BASE_RST;
      ring_log2 <= `RXR_LOG2_RST;
    end else if (wr) begin
      if (paddr == `RXR_CTRL_OFS) begin
        run <= pwdata[`RXR_RUN_BIT];
      end
      // Entries stay on eight-byte boundaries
      if (paddr == `RXR_BASE_OFS) begin
        ring_base <= {pwdata[23:3], 3'b000};
      end
      if (paddr == `RXR_LEN_OFS) begin
        ring_log2 <= (pwdata[2:0] > LOG2_MAX) ? LOG2_MAX : pwdata[2:0];
      end
    end
  end
endmodule : rxr_apb_regs
`default_nettype wire

// >>> rxr_defines.svh
`ifndef RXR_DEFINES_SVH
`define RXR_DEFINES_SVH

// =====================================================
// Register offsets on the bus
`define RXR_CTRL_OFS 8'h00
`define RXR_BASE_OFS 8'h04
`define RXR_LEN_OFS 8'h08
`define RXR_STAT_OFS 8'h0c
`define RXR_RUN_BIT 0

// =====================================================
// Entry layout: byte offset of each word, status bits
`define RXR_W0_OFS 24'h000000
`define RXR_W1_OFS 24'h000002
`define RXR_W2_OFS 24'h000004
`define RXR_W3_OFS 24'h000006
`define RXR_OWN_BIT 15
`define RXR_ERR_BIT 14
`define RXR_FIRST_BIT 9
`define RXR_LAST_BIT 8
`define RXR_LOG2_RST 3'h0
`define RXR_BASE_RST 24'h000000
`endif

// >>> rxr_host_mem.sv
`default_nettype none
// =====================================================
// Host memory partner: 16-bit words, byte addresses
module rxr_host_mem (
  // Clock
  input wire logic clk,
  // Memory port
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [23:0] mem_addr,
  input wire logic [15:0] mem_wdata,
  output logic mem_ack,
  output logic [15:0] mem_rdata,
  // Test control
  input wire logic slow
);
  timeunit 1ns;
  timeprecision 1ns;
  // Upper address bits alias: only 8 KB are modelled
  logic [15:0] mem [0:4095];
  int wait_cnt = 0;
  int n_acc = 0;
  int n_wr = 0;
  int n_viol = 0;
  logic [11:0] w1_idx;
  logic take;
  assign w1_idx = {mem_addr[12:3], 2'b01};
  assign take = mem_req && !mem_ack && wait_cnt == 0;
  initial begin
    mem_ack = 1'b0;
    mem_rdata = 16'h0000;
  end
  always @(posedge clk) begin
    mem_ack <= take;
    // Data lines never keep the last value once released
    mem_rdata <= (take && !mem_we) ? mem[mem_addr[12:1]] : ~mem_rdata;
    if (mem_req && !mem_ack && wait_cnt > 0) begin
      wait_cnt <= wait_cnt - 1;
    end
    if (take) begin
      n_acc <= n_acc + 1;
      wait_cnt <= slow ? 20 : $urandom_range(0, 2);
      if (mem_we) begin
        n_wr <= n_wr + 1;
        if (mem_addr[12:6] == 7'h04 && !mem[w1_idx][15]) begin
          n_viol <= n_viol + 1;
        end
        mem[mem_addr[12:1]] <= mem_wdata;
      end
    end
  end
endmodule : rxr_host_mem
`default_nettype wire

// >>> rxr_pkg.sv
`default_nettype none
package rxr_pkg;
  // Gray steps along poll, fetch, store, write-back
  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_POLL = 4'h1,
    ST_RD_W0 = 4'h3,
    ST_RD_W2 = 4'h2,
    ST_READY = 4'h6,
    ST_STORE = 4'h7,
    ST_WR_W3 = 4'h5,
    ST_WR_W1 = 4'h4,
    ST_NXT_W1 = 4'he,
    ST_DROP = 4'hc
  } rxr_state_t;
endpackage : rxr_pkg
`default_nettype wire

// >>> rxr_ring_handler.sv
`include "rxr_defines.svh"
`default_nettype none
module rxr_ring_handler
  import rxr_pkg::*;
#(
  parameter int RING_LOG2_MAX = 7
) (
  // Clock and reset
  input wire logic CLOCK,
  input wire logic NRST,
  // APB slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // Host memory master, 16-bit words, byte addresses
  output logic MEM_REQ,
  output logic MEM_WE,
  output logic [23:0] MEM_ADDR,
  output logic [15:0] MEM_WDATA,
  input wire logic MEM_ACK,
  input wire logic [15:0] MEM_RDATA,
  // Received byte stream
  input wire logic RX_VALID,
  input wire logic [7:0] RX_DATA,
  input wire logic RX_LAST,
  input wire logic RX_CRC_ERR,
  input wire logic RX_ODD_BITS
);
  if (RING_LOG2_MAX < 0 || RING_LOG2_MAX > 7) begin : g_chk
    $error("RING_LOG2_MAX must lie in 0..7");
  end

  // =====================================================
  // Registers and byte packer
  logic run;
  logic [23:0] ring_base;
  logic [2:0] ring_log2;
  rxr_state_t st_reg, st_next;
  logic [6:0] idx_reg, idx_next, idx_inc, idx_mask;
  logic w_valid, w_two, w_last, w_crc, w_odd, overrun, w_take;
  logic [15:0] w_data;

  rxr_apb_regs #(.LOG2_MAX(3'(RING_LOG2_MAX))) u_regs (
    .clk(CLOCK),
    .nrst(NRST),
    .psel(PSEL),
    .penable(PENABLE),
    .pwrite(PWRITE),
    .paddr(PADDR),
    .pwdata(PWDATA),
    .prdata(PRDATA),
    .pready(PREADY),
    .pslverr(PSLVERR),
    .run(run),
    .ring_base(ring_base),
    .ring_log2(ring_log2),
    .idx(idx_reg),
    .state(st_reg)
  );

  rxr_word_pack u_pack (
    .clk(CLOCK),
    .nrst(NRST),
    .en(run),
    .in_valid(RX_VALID),
    .in_data(RX_DATA),
    .in_last(RX_LAST),
    .in_crc(RX_CRC_ERR),
    .in_odd(RX_ODD_BITS),
    .take(w_take),
    .w_valid(w_valid),
    .w_data(w_data),
    .w_two(w_two),
    .w_last(w_last),
    .w_crc(w_crc),
    .w_odd(w_odd),
    .overrun(overrun)
  );

  // =====================================================
  // Entry bookkeeping
  logic [23:0] buf_reg, ent_addr, nxt_addr, addr_next, cur_addr;
  logic [11:0] off_reg, rem_reg, len_reg, len_add, bytes;
  logic [7:0] upper_address_byte_reg, nxt_upper_address_byte_reg;
  logic first_reg, fin_reg, drop_reg, drop_next, ack;
  logic [3:0] fl_reg, fl_next; // alignment_fault_flag, overrun, crc, chain fault
  logic [15:0] status, wdata_next;
  logic owned, full, out_load, acc_next, we_next;

  assign ack = MEM_REQ && MEM_ACK;
  assign owned = MEM_RDATA[`RXR_OWN_BIT];
  assign bytes = w_two ? 12'h002 : 12'h001;
  assign len_add = len_reg + bytes;
  assign full = rem_reg <= bytes;
  assign idx_mask = 7'((8'h01 << ring_log2) - 8'h01);
  assign idx_inc = (idx_reg + 7'h01) & idx_mask;
  assign ent_addr = ring_base + {14'h0000, idx_reg, 3'b000};
  assign nxt_addr = ring_base + {14'h0000, idx_inc, 3'b000};
  // The index moves on at the hand-back edge, so the fetch launched there
  // must already point at the following entry
  assign cur_addr = (st_reg == ST_WR_W1) ? nxt_addr : ent_addr;

  // Words with no buffer behind them are thrown away
  always_comb begin
    w_take = 1'b0;
    case (st_reg)
      ST_STORE: w_take = ack;
      ST_DROP, ST_POLL, ST_IDLE: w_take = w_valid;
      default: w_take = 1'b0;
    endcase
  end

  always_comb begin
    drop_next = drop_reg;
    if (w_take && (st_reg == ST_POLL || st_reg == ST_IDLE)) begin
      drop_next = !w_last;
    end
  end

  always_comb begin
    fl_next = fl_reg;
    if (st_reg == ST_POLL && ack) begin
      fl_next = 4'h0;
    end else begin
      if (st_reg == ST_STORE && w_take && w_last && w_crc) begin
        fl_next[1] = 1'b1;
        fl_next[3] = w_odd;
      end
      if (overrun && st_reg != ST_POLL && st_reg != ST_IDLE &&
          st_reg != ST_WR_W1 && st_reg != ST_WR_W3) begin
        fl_next[2] = 1'b1;
      end
      if (st_reg == ST_NXT_W1 && (overrun || (ack && !owned))) begin
        fl_next[0] = 1'b1;
      end
    end
  end

  // Error summary, own handed back, first and last markers, high byte
  assign status = {1'b0, |fl_next, fl_next, first_reg,
                   fin_reg && !fl_next[0], upper_address_byte_reg};

  // =====================================================
  // Sequencer
  always_comb begin
    st_next = st_reg;
    idx_next = idx_reg;
    case (st_reg)
      ST_IDLE: if (run) st_next = ST_POLL;
      ST_POLL: begin
        if (ack && !run) begin
          st_next = ST_IDLE;
        end else if (ack && owned && !drop_next) begin
          st_next = ST_RD_W0;
        end
      end
      ST_RD_W0: if (ack) st_next = ST_RD_W2;
      ST_RD_W2: if (ack) st_next = ST_READY;
      ST_READY: if (w_valid) st_next = ST_STORE;
      ST_STORE: begin
        if (ack && w_last) begin
          st_next = ST_WR_W3;
        end else if (ack && full) begin
          st_next = ST_NXT_W1;
        end else if (ack) begin
          st_next = ST_READY;
        end
      end
      ST_NXT_W1: begin
        if (ack && (fl_next[0] || fl_reg[0])) begin
          st_next = ST_DROP;
        end else if (ack) begin
          st_next = ST_WR_W1;
        end
      end
      ST_DROP: if (w_take && w_last) st_next = ST_WR_W1;
      ST_WR_W3: if (ack) st_next = ST_WR_W1;
      ST_WR_W1: begin
        if (ack) begin
          idx_next = idx_inc;
          st_next = fin_reg ? ST_POLL : ST_RD_W0;
        end
      end
      default: st_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      st_reg <= ST_IDLE;
      idx_reg <= 7'h00;
      drop_reg <= 1'b0;
      fl_reg <= 4'h0;
    end else begin
      st_reg <= st_next;
      idx_reg <= run ? idx_next : 7'h00;
      drop_reg <= drop_next;
      fl_reg <= fl_next;
    end
  end

  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      upper_address_byte_reg <= 8'h00;
      nxt_upper_address_byte_reg <= 8'h00;
      buf_reg <= 24'h000000;
      first_reg <= 1'b0;
      fin_reg <= 1'b0;
    end else if (ack) begin
      case (st_reg)
        ST_POLL: begin
          upper_address_byte_reg <= MEM_RDATA[7:0];
          first_reg <= 1'b1;
          fin_reg <= 1'b0;
        end
        ST_RD_W0: buf_reg <= {upper_address_byte_reg, MEM_RDATA};
        ST_STORE: fin_reg <= w_last;
        ST_NXT_W1: begin
          nxt_upper_address_byte_reg <= MEM_RDATA[7:0];
          fin_reg <= fl_next[0];
        end
        ST_WR_W1: begin
          upper_address_byte_reg <= nxt_upper_address_byte_reg;
          first_reg <= 1'b0;
        end
        default: buf_reg <= buf_reg;
      endcase
    end else if (st_reg == ST_DROP && w_take && w_last) begin
      fin_reg <= 1'b1;
    end
  end

  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      off_reg <= 12'h000;
      rem_reg <= 12'h000;
      len_reg <= 12'h000;
    end else if (ack && st_reg == ST_RD_W2) begin
      off_reg <= 12'h000;
      rem_reg <= 12'h000 - MEM_RDATA[11:0];
      if (first_reg) begin
        len_reg <= 12'h000;
      end
    end else if (ack && st_reg == ST_STORE) begin
      off_reg <= off_reg + 12'h002;
      rem_reg <= full ? 12'h000 : rem_reg - bytes;
      len_reg <= len_add;
    end
  end

  // =====================================================
  // Memory request stage; held stable until acknowledged
  always_comb begin
    addr_next = cur_addr;
    wdata_next = 16'h0000;
    we_next = 1'b0;
    acc_next = 1'b1;
    case (st_next)
      ST_POLL: addr_next = cur_addr + `RXR_W1_OFS;
      ST_RD_W0: addr_next = cur_addr + `RXR_W0_OFS;
      ST_RD_W2: addr_next = ent_addr + `RXR_W2_OFS;
      ST_NXT_W1: addr_next = nxt_addr + `RXR_W1_OFS;
      ST_STORE: begin
        addr_next = buf_reg + {12'h000, off_reg};
        wdata_next = w_data;
        we_next = 1'b1;
      end
      ST_WR_W3: begin
        addr_next = ent_addr + `RXR_W3_OFS;
        wdata_next = {4'h0, len_add};
        we_next = 1'b1;
      end
      ST_WR_W1: begin
        addr_next = ent_addr + `RXR_W1_OFS;
        wdata_next = status;
        we_next = 1'b1;
      end
      default: acc_next = 1'b0;
    endcase
  end

  assign out_load = !MEM_REQ || MEM_ACK;

  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      MEM_REQ <= 1'b0;
      MEM_WE <= 1'b0;
      MEM_ADDR <= 24'h000000;
      MEM_WDATA <= 16'h0000;
    end else if (out_load) begin
      MEM_REQ <= acc_next;
      MEM_WE <= we_next;
      MEM_ADDR <= addr_next;
      MEM_WDATA <= wdata_next;
    end
  end

  // =====================================================
  // Checks
  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (!NRST);

  sequence s_w3_done;
    st_reg == ST_WR_W3 && ack;
  endsequence
  sequence s_chain_miss;
    st_reg == ST_NXT_W1 && ack && !owned;
  endsequence

  a_own_handback: assert property (
    MEM_REQ && st_reg == ST_WR_W1 |-> MEM_WE && !MEM_WDATA[15])
    else $error("status write keeps ownership");
  a_err_summary: assert property (
    MEM_REQ && st_reg == ST_WR_W1 |-> MEM_WDATA[14] == |MEM_WDATA[13:10])
    else $error("error summary mismatch");
  a_alignment_fault_flag_crc: assert property (
    MEM_REQ && st_reg == ST_WR_W1 && MEM_WDATA[13] |-> MEM_WDATA[11])
    else $error("alignment fault without checksum error");
  a_upper_address_byte_kept: assert property (
    MEM_REQ && st_reg == ST_WR_W1 |-> MEM_WDATA[7:0] == upper_address_byte_reg)
    else $error("high address byte altered");
  a_w3_reserved: assert property (
    MEM_REQ && st_reg == ST_WR_W3 |-> MEM_WDATA[15:12] == 4'h0)
    else $error("reserved length bits not zero");
  a_w3_then_w1: assert property (
    s_w3_done |=> st_reg == ST_WR_W1 && MEM_REQ && MEM_WDATA[8])
    else $error("length write not followed by last status");
  a_chain_fault: assert property (
    s_chain_miss |=> st_reg == ST_DROP && fl_reg[0])
    else $error("unowned next entry not flagged");
  a_start_owned: assert property (
    st_reg == ST_RD_W0 && $past(st_reg) == ST_POLL |-> $past(owned))
    else $error("fetch from an unowned entry");
  a_poll_read: assert property (
    MEM_REQ && (st_reg == ST_POLL || st_reg == ST_NXT_W1) |-> !MEM_WE)
    else $error("write while ownership unknown");
  a_run_gate: assert property (
    st_reg == ST_IDLE && !run |=> st_reg == ST_IDLE && !MEM_REQ)
    else $error("activity without run");
  a_lookahead: assert property (
    MEM_REQ && st_reg == ST_NXT_W1 |-> MEM_ADDR == nxt_addr + 24'h000002)
    else $error("look-ahead beyond next entry");
endmodule : rxr_ring_handler
`default_nettype wire

// >>> rxr_word_pack.sv
`default_nettype none
module rxr_word_pack (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Byte side
  input wire logic en,
  input wire logic in_valid,
  input wire logic [7:0] in_data,
  input wire logic in_last,
  input wire logic in_crc,
  input wire logic in_odd,
  // Word side
  input wire logic take,
  output logic w_valid,
  output logic [15:0] w_data,
  output logic w_two,
  output logic w_last,
  output logic w_crc,
  output logic w_odd,
  output logic overrun
);
  logic half_reg;
  logic [7:0] lo_reg;
  logic complete;

  assign complete = in_valid && en && (half_reg || in_last);
  // One word of holding: a second word before the first is taken is lost
  assign overrun = complete && w_valid && !take;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      half_reg <= 1'b0;
      lo_reg <= 8'h00;
    end else if (in_valid && en) begin
      half_reg <= !half_reg && !in_last;
      if (!half_reg) begin
        lo_reg <= in_data;
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      w_valid <= 1'b0;
      w_data <= 16'h0000;
      w_two <= 1'b0;
      w_last <= 1'b0;
      w_crc <= 1'b0;
      w_odd <= 1'b0;
    end else if (complete && (!w_valid || take)) begin
      w_valid <= 1'b1;
      w_data <= half_reg ? {in_data, lo_reg} : {8'h00, in_data};
      w_two <= half_reg;
      w_last <= in_last;
      w_crc <= in_last && in_crc;
      w_odd <= in_last && in_odd;
    end else if (complete) begin
      // A lost word must not hide the end of its packet
      w_last <= w_last || in_last;
      w_crc <= w_crc || (in_last && in_crc);
      w_odd <= w_odd || (in_last && in_odd);
    end else if (take) begin
      w_valid <= 1'b0;
    end
  end

  a_overrun_cause: assert property (@(posedge clk) disable iff (!nrst)
    overrun |-> w_valid && !take && in_valid && (half_reg || in_last))
    else $error("overrun without a held word");
endmodule : rxr_word_pack
`default_nettype wire

// >>> tb_top.sv
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock, nrst, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr, rx_data;
  logic [31:0] pwdata, prdata;
  logic mem_req, mem_we, mem_ack, slow;
  logic [23:0] mem_addr;
  logic [15:0] mem_wdata, mem_rdata;
  logic rx_valid, rx_last, rx_crc, rx_odd;
  int num_errors = 0;
  int n_tests = 0;
  logic [7:0] pkt [0:127];
  logic [7:0] upper_address_byte [0:7];

  rxr_ring_handler #(.RING_LOG2_MAX(7)) u_rxr_ring_handler (
    .CLOCK(clock), .NRST(nrst), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .MEM_REQ(mem_req),
    .MEM_WE(mem_we), .MEM_ADDR(mem_addr), .MEM_WDATA(mem_wdata),
    .MEM_ACK(mem_ack), .MEM_RDATA(mem_rdata), .RX_VALID(rx_valid),
    .RX_DATA(rx_data), .RX_LAST(rx_last), .RX_CRC_ERR(rx_crc),
    .RX_ODD_BITS(rx_odd));
  rxr_host_mem u_rxr_host_mem (
    .clk(clock), .mem_req(mem_req), .mem_we(mem_we),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ack(mem_ack),
    .mem_rdata(mem_rdata), .slow(slow));

  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  // =====================================================
  // Checks and report
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : end_sim

  task automatic check16(input string s, input logic [15:0] e,
                         input logic [15:0] g);
    n_tests++;
    if (g !== e) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", s, e, g);
    end
  endtask : check16

  task automatic check32(input string s, input logic [31:0] e,
                         input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", s, e, g);
    end
  endtask : check32

  function automatic logic [15:0] exp_w1(input logic crc, odd, ovr, chn,
                                         fst, lst, input logic [7:0] h);
    logic alignment_fault_flag;
    // Odd bit count alone never flags alignment
    alignment_fault_flag = crc & odd;
    return {1'b0, alignment_fault_flag | ovr | crc | chn, alignment_fault_flag, ovr, crc, chn, fst, lst, h};
  endfunction : exp_w1

  // =====================================================
  // Drivers
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q,
                     output logic err);
    int k;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    penable <= 1'b0;
    @(posedge clock);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clock);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (k >= 50) begin
      num_errors++;
      end_sim();
    end
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask : apb

  task automatic send_pkt(input int n, input int gap, input logic crc,
                          input logic odd);
    for (int i = 0; i < n; i++) begin
      pkt[i] = 8'($urandom);
      rx_valid <= 1'b1;
      rx_data <= pkt[i];
      rx_last <= (i == n - 1);
      rx_crc <= (i == n - 1) & crc;
      rx_odd <= (i == n - 1) & odd;
      @(posedge clock);
      if (gap > 1) begin
        rx_valid <= 1'b0;
        repeat (gap - 1) @(posedge clock);
      end
    end
    rx_valid <= 1'b0;
    rx_last <= 1'b0;
    @(posedge clock);
  endtask : send_pkt

  task automatic set_entry(input int e, input logic own);
    upper_address_byte[e] = 8'($urandom);
    u_rxr_host_mem.mem[128 + e * 4] = 16'(1024 + e * 128);
    u_rxr_host_mem.mem[130 + e * 4] = 16'hffc0;
    u_rxr_host_mem.mem[131 + e * 4] = 16'h0000;
    // Ownership goes last, once the other words are in place
    u_rxr_host_mem.mem[129 + e * 4] = {own, 7'h00, upper_address_byte[e]};
  endtask : set_entry

  task automatic wait_done(input int e);
    int k;
    k = 0;
    while (u_rxr_host_mem.mem[129 + e * 4][15] !== 1'b0 && k < 5000) begin
      @(posedge clock);
      k++;
    end
    if (k >= 5000) begin
      num_errors++;
      $display("mismatch entry %0d expected 0 seen 1", e);
      end_sim();
    end
    @(posedge clock);
  endtask : wait_done

  task automatic chk_entry(input int e, input logic [15:0] w1,
                           input logic [15:0] w3, input logic [15:0] m3,
                           input int off, input int nb);
    int w;
    logic [15:0] x;
    w = 128 + e * 4;
    check16("w0", 16'(1024 + e * 128), u_rxr_host_mem.mem[w]);
    check16("w1", w1, u_rxr_host_mem.mem[w + 1]);
    check16("w2", 16'hffc0, u_rxr_host_mem.mem[w + 2]);
    check16("w3", w3 & m3, u_rxr_host_mem.mem[w + 3] & m3);
    for (int k = 0; k < nb; k += 2) begin
      x = {(k + 1 < nb) ? pkt[off + k + 1] : 8'h00, pkt[off + k]};
      check16("data", x, u_rxr_host_mem.mem[512 + e * 64 + k / 2]);
    end
  endtask : chk_entry

  // =====================================================
  // Main sequence
  initial begin
    logic [31:0] q;
    logic err;
    int n;
    void'($urandom(32'ha80f6d72));
    {nrst, psel, penable, pwrite, slow} = 5'h00;
    {rx_valid, rx_last, rx_crc, rx_odd} = 4'h0;
    paddr = 8'h00;
    pwdata = 32'h00000000;
    rx_data = 8'h00;
    repeat (4) @(posedge clock);
    nrst <= 1'b1;
    @(posedge clock);
    apb(1'b0, 8'h00, 32'h0, q, err);
    check32("ctrl", 32'h0, q);
    apb(1'b0, 8'h0c, 32'h0, q, err);
    check32("status", 32'h0, q);
    apb(1'b0, 8'h10, 32'h0, q, err);
    check32("slverr", 32'h1, {31'h0, err});
    apb(1'b1, 8'h04, 32'h00000105, q, err);
    apb(1'b0, 8'h04, 32'h0, q, err);
    check32("base", 32'h00000100, q);
    apb(1'b1, 8'h08, 32'h3, q, err);
    apb(1'b0, 8'h08, 32'h0, q, err);
    check32("log2", 32'h3, q);
    for (int e = 0; e < 8; e++) set_entry(e, e != 7);
    send_pkt(8, 2, 1'b0, 1'b0);
    check32("idle accesses", 32'h0, u_rxr_host_mem.n_acc);
    apb(1'b1, 8'h00, 32'h1, q, err);
    $display("end of test registers");
    for (int i = 0; i < 4; i++) begin
      n = (i == 0) ? 64 : $urandom_range(1, 63);
      send_pkt(n, 16, i[0], i[1]);
      wait_done(i);
      chk_entry(i, exp_w1(i[0], i[1], 1'b0, 1'b0, 1'b1, 1'b1, upper_address_byte[i]),
                {4'h0, 12'(n)}, i[0] ? 16'hf000 : 16'hffff, 0, n);
    end
    $display("end of test single buffer");
    send_pkt(100, 16, 1'b0, 1'b0);
    wait_done(5);
    chk_entry(4, exp_w1(0, 0, 0, 0, 1, 0, upper_address_byte[4]), 16'h0, 16'hffff,
              0, 64);
    chk_entry(5, exp_w1(0, 0, 0, 0, 0, 1, upper_address_byte[5]), 16'h0064, 16'hffff,
              64, 36);
    $display("end of test chaining");
    send_pkt(80, 16, 1'b0, 1'b0);
    wait_done(6);
    chk_entry(6, exp_w1(0, 0, 0, 1, 1, 0, upper_address_byte[6]), 16'h0, 16'hffff,
              0, 64);
    n = u_rxr_host_mem.n_wr;
    send_pkt(10, 16, 1'b0, 1'b0);
    repeat (20) @(posedge clock);
    check32("unowned writes", n, u_rxr_host_mem.n_wr);
    check16("w1 unowned", {8'h00, upper_address_byte[7]},
            u_rxr_host_mem.mem[157]);
    $display("end of test chain fault");
    set_entry(0, 1'b1);
    set_entry(7, 1'b1);
    repeat (10) @(posedge clock);
    slow <= 1'b1;
    send_pkt(20, 1, 1'b0, 1'b0);
    slow <= 1'b0;
    wait_done(7);
    check16("w1 overrun", 16'h5000,
            u_rxr_host_mem.mem[157] & 16'hd000);
    send_pkt(6, 16, 1'b1, 1'b0);
    wait_done(0);
    chk_entry(0, exp_w1(1, 0, 0, 0, 1, 1, upper_address_byte[0]), 16'h0, 16'hf000,
              0, 6);
    check32("foreign writes", 32'h0, u_rxr_host_mem.n_viol);
    $display("end of test overrun and wrap");
    end_sim();
  end

  initial begin
    repeat (100000) @(posedge clock);
    num_errors++;
    end_sim();
  end
endmodule : tb_top
`default_nettype wire
